// ---- design/port_cmd_map.vh ----
// Constants for the port resume record handler.
// Summary of operation
// R1 - Controller resumes only after device reconnected.
// R2 - Records use identifier 0, index 0xB400.
// R3 - Write frame: 08,port,FE,4A,02,FF,FF,cmd.
// R4 - Reply is twelve bytes: command, PDU, job.
// R5 - Status byte 00 ok, 80 error PDU.
// R6 - Success echoes command, zero status and errors.
// R7 - Unfinished resume answers busy code 0x80C2.
// R8 - Controller reads status after every write.
// R9 - Suspend uses code 03, same frame layout.
`ifndef PORT_CMD_MAP_VH
`define PORT_CMD_MAP_VH
`define REC_ID          8'h00
`define REC_INDEX       16'hb400
`define WR_LEN          4'h8
`define RD_LEN          4'hc
`define HDR_BYTE        8'h08
`define FIX0_BYTE       8'hfe
`define FIX1_BYTE       8'h4a
`define CALL_WRITE      8'h02
`define CMD_IDX_BYTE    8'hff
`define CMD_SUSPEND     8'h03
`define CMD_RESUME      8'h04
`define STAT_OK         8'h00
`define STAT_ERR        8'h80
`define ERR_NONE        16'h0000
`define ERR_INCORRECT   16'h7001
`define ERR_PORT_NUM    16'h8001
`define ERR_INDEX       16'h8002
`define ERR_DECODE      16'h8051
`define ERR_NOT_SUPP    16'h8057
`define NEG_BUSY        16'h80c2
`define PORT_MIN        8'h01
`define PORT_MAX        8'h08
`endif

// ---- design/frame_check.v ----
// Combinational decode of a captured eight-byte command frame.
`timescale 1ns/1ps
`include "port_cmd_map.vh"
module frame_check (
    input  wire [63:0] i_frame,
    output reg  [15:0] o_err_code
);
    wire [7:0] b0;
    wire [7:0] b1;
    wire [7:0] b2;
    wire [7:0] b3;
    wire [7:0] b4;
    wire [7:0] b5;
    wire [7:0] b6;
    wire [7:0] b7;
    assign b0 = i_frame[7:0];
    assign b1 = i_frame[15:8];
    assign b2 = i_frame[23:16];
    assign b3 = i_frame[31:24];
    assign b4 = i_frame[39:32];
    assign b5 = i_frame[47:40];
    assign b6 = i_frame[55:48];
    assign b7 = i_frame[63:56];
    always @* begin
        o_err_code = `ERR_NONE;
        if (b0 != `HDR_BYTE || b2 != `FIX0_BYTE || b3 != `FIX1_BYTE)
            o_err_code = `ERR_DECODE; // [R3]
        else if (b4 != `CALL_WRITE)
            o_err_code = `ERR_INCORRECT; // [R3]
        else if (b1 < `PORT_MIN || b1 > `PORT_MAX)
            o_err_code = `ERR_PORT_NUM; // [R3]
        else if (b5 != `CMD_IDX_BYTE || b6 != `CMD_IDX_BYTE)
            o_err_code = `ERR_INDEX; // [R3]
        else if (b7 != `CMD_RESUME && b7 != `CMD_SUSPEND)
            o_err_code = `ERR_NOT_SUPP; // [R5] [R9]
    end
endmodule // frame_check

// ---- design/port_resume_record_handler.v ----
// Record write/read handler for port suspend and resume commands.
`timescale 1ns/1ps
`include "port_cmd_map.vh"
module port_resume_record_handler (
    input  wire        i_clk_sys,
    input  wire        i_rst_b,
    input  wire        i_wr_start,
    input  wire        i_wr_valid,
    input  wire [7:0]  i_wr_byte,
    input  wire        i_rd_req,
    input  wire [7:0]  i_rec_id,
    input  wire [15:0] i_rec_index,
    input  wire        i_port_done,
    input  wire [15:0] i_job_err,
    output reg         o_cmd_valid,
    output reg  [7:0]  o_cmd_port,
    output reg  [7:0]  o_cmd_code,
    output reg         o_rd_valid,
    output reg  [7:0]  o_rd_byte,
    output reg         o_rd_last,
    output reg         o_busy_nak,
    output reg  [15:0] o_nak_code,
    output reg         o_wr_nak
);
    localparam ST_IDLE = 3'b001;
    localparam ST_WR   = 3'b010;
    localparam ST_RD   = 3'b100;

    // Control state and the byte counter shared by writes and reads.
    reg [2:0]   state_reg;
    reg [2:0]   state_next;
    reg [3:0]   cnt_reg;
    reg [3:0]   cnt_next;
    // Captured command frame, byte 0 in the lowest eight bits.
    reg [63:0]  frame_reg;
    // A port job has been issued and its completion is still awaited.
    reg         pending_reg;
    reg         pending_next;
    reg [15:0]  err_reg;
    reg [15:0]  job_reg;
    reg         wr_done_reg;
    wire [15:0] chk_err;
    wire        addr_ok;
    wire        is_idle;
    wire        req_bad;
    wire        wr_take;
    wire        rd_take;
    wire        rd_busy;
    wire        wr_last;
    wire        rd_last;
    wire        job_end;
    wire        cmd_ok;
    wire [5:0]  wr_pos;
    wire [6:0]  rd_pos;
    wire [95:0] reply;
    wire [7:0]  stat_byte;

    frame_check u_check (
        .i_frame    (frame_reg),
        .o_err_code (chk_err)
    );

    assign addr_ok = (i_rec_id == `REC_ID) &&
                     (i_rec_index == `REC_INDEX); // [R2]
    assign is_idle = (state_reg == ST_IDLE);
    // Requests to any other record are refused, reads as well as writes.
    assign req_bad = is_idle && (i_wr_start || i_rd_req) &&
                     !addr_ok; // [R2]
    assign wr_take = is_idle && i_wr_start && addr_ok; // [R2]
    // A job that ends in the cycle of the read no longer counts as busy,
    // so the read is served instead of being lost.
    assign job_end = pending_reg && i_port_done;
    assign rd_take = is_idle && !i_wr_start && i_rd_req && addr_ok &&
                     (!pending_reg || i_port_done); // [R8]
    assign rd_busy = is_idle && !i_wr_start && i_rd_req && addr_ok &&
                     pending_reg && !i_port_done; // [R7]
    assign wr_last = (state_reg == ST_WR) && i_wr_valid &&
                     (cnt_reg == `WR_LEN - 4'h1);
    assign rd_last = (state_reg == ST_RD) &&
                     (cnt_reg == `RD_LEN - 4'h1); // [R4]
    assign cmd_ok  = (chk_err == `ERR_NONE);
    assign wr_pos  = {cnt_reg[2:0], 3'b000};
    assign rd_pos  = {cnt_reg, 3'b000};

    // A reply carries the error PDU only when one of its fields is nonzero.
    assign stat_byte = (err_reg == `ERR_NONE && job_reg == `ERR_NONE) ?
                       `STAT_OK : `STAT_ERR; // [R5]
    assign reply = {job_reg[7:0], job_reg[15:8], err_reg[7:0],
                    err_reg[15:8], frame_reg[63:40], stat_byte,
                    frame_reg[31:0]}; // [R4] [R6]

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (wr_take)
                    state_next = ST_WR;
                else if (rd_take)
                    state_next = ST_RD;
            end
            ST_WR: begin
                if (wr_last)
                    state_next = ST_IDLE;
            end
            ST_RD: begin
                if (rd_last)
                    state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always @* begin
        cnt_next = cnt_reg;
        case (state_reg)
            ST_IDLE: cnt_next = 4'h0;
            ST_WR: begin
                if (i_wr_valid)
                    cnt_next = cnt_reg + 4'h1;
            end
            ST_RD: cnt_next = cnt_reg + 4'h1;
            default: cnt_next = 4'h0;
        endcase
    end

    // A newly issued command wins over a completion in the same cycle,
    // since that completion belongs to the job before it.
    always @* begin
        pending_next = pending_reg;
        if (job_end)
            pending_next = 1'b0;
        if (wr_done_reg && cmd_ok)
            pending_next = 1'b1;
    end

    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            state_reg   <= ST_IDLE;
            cnt_reg     <= 4'h0;
            pending_reg <= 1'b0;
            wr_done_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            pending_reg <= pending_next;
            // The frame is judged one cycle after its last byte lands.
            wr_done_reg <= wr_last;
        end
    end

    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            frame_reg <= 64'h0;
        end else if (wr_take) begin
            frame_reg <= 64'h0;
        end else if (state_reg == ST_WR && i_wr_valid) begin
            frame_reg[wr_pos +: 8] <= i_wr_byte; // [R3]
        end
    end

    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            err_reg <= 16'h0;
            job_reg <= 16'h0;
        end else begin
            if (wr_done_reg)
                err_reg <= chk_err; // [R5]
            // A new command forgets the job error of the one before it.
            if (wr_done_reg)
                job_reg <= `ERR_NONE;
            else if (job_end)
                job_reg <= i_job_err; // [R6]
        end
    end

    // Only a frame that passed every check reaches the port logic.
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_cmd_valid <= 1'b0;
            o_cmd_port  <= 8'h0;
            o_cmd_code  <= 8'h0;
        end else begin
            o_cmd_valid <= wr_done_reg && cmd_ok; // [R9]
            if (wr_done_reg && cmd_ok) begin
                o_cmd_port <= frame_reg[15:8];
                o_cmd_code <= frame_reg[63:56];
            end
        end
    end

    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_rd_valid <= 1'b0;
            o_rd_byte  <= 8'h0;
            o_rd_last  <= 1'b0;
        end else begin
            o_rd_valid <= (state_reg == ST_RD); // [R4]
            o_rd_last  <= rd_last; // [R4]
            if (state_reg == ST_RD)
                o_rd_byte <= reply[rd_pos +: 8]; // [R4]
        end
    end

    // The busy code stays put between answers; only the pulse marks one.
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_busy_nak <= 1'b0;
            o_nak_code <= 16'h0;
            o_wr_nak   <= 1'b0;
        end else begin
            o_wr_nak   <= req_bad; // [R2]
            o_busy_nak <= rd_busy; // [R7]
            if (rd_busy)
                o_nak_code <= `NEG_BUSY; // [R7]
        end
    end
endmodule // port_resume_record_handler

// ---- tb/ctrl_model.sv ----
// Fieldbus controller model issuing record writes and reads.
`timescale 1ns/1ps
module ctrl_model (
    input  wire        i_clk,
    output reg         o_start,
    output reg         o_valid,
    output reg  [7:0]  o_byte,
    output reg         o_rd,
    output reg  [23:0] o_addr
);
    initial {o_start, o_valid, o_byte, o_rd, o_addr} = 0;
    task send(input [7:0] p, input [7:0] c, input [23:0] a);
        integer k;
        reg [63:0] f;
        begin
            f = {8'h08, p, 8'hfe, 8'h4a, 8'h02, 8'hff, 8'hff, c};
            @(negedge i_clk);
            o_addr = a;
            o_start = 1'b1;
            for (k = 0; k < 8; k = k + 1) begin
                @(negedge i_clk);
                o_start = 1'b0;
                o_valid = 1'b1;
                o_byte = f[63-8*k -: 8];
            end
            @(negedge i_clk);
            o_valid = 1'b0;
            // A released data line shows the inverse so stale bytes stand out.
            o_byte = ~o_byte;
        end
    endtask
    task read;
        begin
            @(negedge i_clk);
            o_rd = 1'b1;
            @(negedge i_clk);
            o_rd = 1'b0;
        end
    endtask
endmodule // ctrl_model

// ---- tb/port_resume_record_handler_properties.sv ----
// Checker of reply framing, busy answers and refusals at the handler.
`timescale 1ns/1ps
module port_resume_record_handler_properties (
    input wire        i_clk_sys,
    input wire        i_rst_b,
    input wire        i_wr_start,
    input wire        i_rd_req,
    input wire [7:0]  i_rec_id,
    input wire [15:0] i_rec_index,
    input wire        o_cmd_valid,
    input wire [7:0]  o_cmd_port,
    input wire [7:0]  o_cmd_code,
    input wire        o_rd_valid,
    input wire        o_rd_last,
    input wire        o_busy_nak,
    input wire [15:0] o_nak_code,
    input wire        o_wr_nak
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    AST_RD_LEN: assert property (
        $rose(o_rd_valid) |-> o_rd_valid[*8] ##1 o_rd_valid[*4] ##0 o_rd_last
        ##1 !o_rd_valid) else $error("reply is not twelve bytes");
    AST_RD_CAUSE: assert property (
        $rose(o_rd_valid) |-> $past(i_rd_req, 2)) else $error("stray reply");
    AST_BUSY: assert property (
        o_busy_nak |-> o_nak_code == 16'h80c2 && !o_rd_valid)
        else $error("busy answer wrong");
    AST_WR_NAK: assert property (
        i_wr_start && (i_rec_id != 8'h00 || i_rec_index != 16'hb400)
        |-> ##[1:3] o_wr_nak) else $error("bad address not refused");
    AST_CMD: assert property (
        o_cmd_valid |-> o_cmd_port inside {[1:8]} && o_cmd_code inside {3, 4})
        else $error("bad command issued");
    AST_LAST: assert property (
        o_rd_last |-> o_rd_valid && !o_busy_nak) else $error("stray last");
endmodule // port_resume_record_handler_properties
bind port_resume_record_handler port_resume_record_handler_properties
    i_props (.*);

// ---- tb/port_resume_record_handler_tb.sv ----
// Self-checking bench for the port resume record handler.
`timescale 1ns/1ps
module port_resume_record_handler_tb;
    reg         clk = 1'b0;
    reg         rst_b = 1'b0;
    reg         done = 1'b0;
    reg  [15:0] jerr = 16'h0000;
    wire        st, vl, rd, cv, rv, rl, bn, wn;
    wire [7:0]  wb, cp, cc, rb;
    wire [15:0] nc;
    wire [23:0] ad;
    integer     err_total = 0;
    integer     num_checks = 0;
    integer     cnt = 0;
    reg         busy = 1'b0;
    reg         nak = 1'b0;
    reg  [95:0] got = 0;
    reg  [15:0] cmd = 0;
    ctrl_model i_ctrl (.i_clk(clk), .o_start(st), .o_valid(vl),
        .o_byte(wb), .o_rd(rd), .o_addr(ad));
    port_resume_record_handler i_dut (.i_clk_sys(clk), .i_rst_b(rst_b),
        .i_wr_start(st), .i_wr_valid(vl), .i_wr_byte(wb), .i_rd_req(rd),
        .i_rec_id(ad[23:16]), .i_rec_index(ad[15:0]), .i_port_done(done),
        .i_job_err(jerr), .o_cmd_valid(cv), .o_cmd_port(cp),
        .o_cmd_code(cc), .o_rd_valid(rv), .o_rd_byte(rb), .o_rd_last(rl),
        .o_busy_nak(bn), .o_nak_code(nc), .o_wr_nak(wn));
    initial forever #10 clk = ~clk;
    always @(negedge clk) begin
        if (rv === 1'b1) begin
            got <= {got[87:0], rb};
            cnt <= cnt + 1;
        end
        if (bn === 1'b1) busy <= 1'b1;
        if (bn === 1'b1) got <= {80'h0, nc};
        if (wn === 1'b1) nak <= 1'b1;
        if (cv === 1'b1) cmd <= {cp, cc};
    end
    task stop_test;
        begin
            $display("checks %0d errors %0d", num_checks, err_total);
            if (err_total == 0 && num_checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task chk(input [95:0] g, input [95:0] e);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("BAD %0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task run(input [7:0] p, input [7:0] c, input [23:0] a, input d);
        integer n;
        begin
            i_ctrl.send(p, c, a);
            @(negedge clk) done = d;
            @(negedge clk) done = 1'b0;
            {cnt, busy} = 0;
            i_ctrl.read;
            for (n = 0; n < 40 && cnt != 12 && !busy; n = n + 1)
                @(negedge clk);
            if (n == 40) begin
                err_total = err_total + 1;
                $display("BAD %0t got %h exp %h", $time, cnt, 12);
                stop_test;
            end
        end
    endtask
    task t_suspend_resume;
        begin
            run(8'h01, 8'h03, 24'h00b400, 1'b0);
            chk(got, 96'h80c2);
            run(8'h01, 8'h03, 24'h00b400, 1'b1);
            chk(got, 96'h0801fe4a00ffff0300000000);
            chk(cmd, 16'h0103);
            // Resume of port 8 follows a confirmed suspend of port 1; nothing checks the order.
            run(8'h08, 8'h04, 24'h00b400, 1'b1);
            chk(got, 96'h0808fe4a00ffff0400000000);
            chk(cmd, 16'h0804);
        end
    endtask
    task t_refusals;
        begin
            run(8'h09, 8'h04, 24'h00b400, 1'b0);
            chk(got, 96'h0809fe4a80ffff0480010000);
            chk(cmd, 16'h0804);
            run(8'h02, 8'h05, 24'h00b400, 1'b0);
            chk(got, 96'h0802fe4a80ffff0580570000);
            chk(cmd, 16'h0804);
            nak = 1'b0;
            i_ctrl.send(8'h01, 8'h04, 24'h01b400);
            chk(nak, 1'b1);
            nak = 1'b0;
            i_ctrl.send(8'h01, 8'h04, 24'h00b401);
            chk(nak, 1'b1);
        end
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        t_suspend_resume;
        t_refusals;
        stop_test;
    end
endmodule // port_resume_record_handler_tb
